/* File: hsc_pkg.sv */
// Package of constants and carrier types for the hot swap capability register set
`default_nettype none
package hsc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] HSC_DWORD_OFFSET    = 8'hE4;
    localparam logic [7:0] HSC_CAP_ID_VALUE    = 8'h06;
    localparam logic [7:0] HSC_NEXT_PTR_VALUE  = 8'h00;
    localparam logic [7:0] HSC_CSR_RESET       = 8'h00;

    // ****************************************
    // Field positions in the dword
    // ****************************************
    localparam int HSC_CAP_ID_LSB   = 0;
    localparam int HSC_NEXT_PTR_LSB = 8;
    localparam int HSC_CSR_LSB      = 16;
    localparam int HSC_INSERT_BIT   = 23;
    localparam int HSC_EXT_BIT      = 22;
    localparam int HSC_LED_BIT      = 19;
    localparam int HSC_MASK_BIT     = 17;
    localparam int HSC_CSR_BYTE     = 2;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  primary_byte_enables_n;
        logic [31:0] wdata;
    } hsc_cfg_req_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } hsc_cfg_rsp_s;

endpackage
`default_nettype wire

/* File: hsc_sync.sv */
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module hsc_sync (
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RESET,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } hsc_sync_s;

    hsc_sync_s st_q;
    hsc_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;
endmodule
`default_nettype wire

/* File: hsc_flag.sv */
// Sticky event flag with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module hsc_flag (
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RESET,
    // Set and clear
    input  wire logic set_evt,
    input  wire logic clr_req,
    // Flag value
    output logic      flag
);
    typedef struct packed {
        logic f;
    } hsc_flag_s;

    hsc_flag_s st_q;
    hsc_flag_s st_d;

    always_comb begin
        st_d = st_q;
        if (clr_req) begin
            st_d.f = 1'b0;
        end
        if (set_evt) begin
            st_d.f = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.f;
endmodule
`default_nettype wire

/* File: hsc_regs.sv */
// Hot swap capability register dword with insertion, extraction, LED and mask
//
// How it works
// - Byte 0 reads the fixed hot swap capability identifier 0x06 and ignores writes.
// - Byte 1 reads the next pointer as zero, ending the capability list, and ignores writes.
// - Identifier, next pointer and control/status share dword 0xE4, control in bits 23:16.
// - The insertion flag sets only once the ejector handle is closed and reset is released.
// - Insertion flag drives enumeration; writing one to bit 23 clears it, zero does nothing.
// - Extraction flag sets on imminent removal, drives enumeration, write one to bit 22 clears.
// - Bit 19 is a read/write LED control, reset zero, lighting the LED when one.
// - Bit 17 is a read/write enumeration mask, reset zero, blocking enumeration when one.
// - Bits 21:20, 18 and 16 read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module hsc_regs (
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET,
    // Configuration access
    input  wire hsc_pkg::hsc_cfg_req_s CFG_REQ,
    output var  hsc_pkg::hsc_cfg_rsp_s CFG_RSP,
    // Board pins
    input  wire logic                  EJECTOR_CLOSED,
    input  wire logic                  REMOVAL_REQUEST,
    output var  logic                  ENUM_N,
    output var  logic                  LED_ON
);
    typedef struct packed {
        logic        handle_was_q;
        logic        removal_was_q;
        logic        indicator_led_control;
        logic        enumeration_mask;
        logic        enum_n;
        logic        rsp_valid;
        logic [31:0] rsp_data;
    } hsc_regs_s;

    hsc_regs_s st_q;
    hsc_regs_s st_d;

    logic handle_sync;
    logic removal_sync;
    logic board_inserted_flag;
    logic extraction_flag;
    logic hit;
    logic csr_wr;
    logic insert_set;
    logic ext_set;
    logic insert_clr;
    logic ext_clr;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    hsc_sync u_sync_handle (
        .MCLK (MCLK),
        .RESET(RESET),
        .din  (EJECTOR_CLOSED),
        .dout (handle_sync)
    );

    hsc_sync u_sync_removal (
        .MCLK (MCLK),
        .RESET(RESET),
        .din  (REMOVAL_REQUEST),
        .dout (removal_sync)
    );

    // ****************************************
    // Decode
    // ****************************************
    // Dword decode
    assign hit    = CFG_REQ.valid && (CFG_REQ.addr == hsc_pkg::HSC_DWORD_OFFSET);
    assign csr_wr = hit && CFG_REQ.write
                    && !CFG_REQ.primary_byte_enables_n[hsc_pkg::HSC_CSR_BYTE];

    // Insertion and extraction set on pin rise, clear on write of one
    assign insert_set = handle_sync && !st_q.handle_was_q;
    assign ext_set    = removal_sync && !st_q.removal_was_q;
    assign insert_clr = csr_wr && CFG_REQ.wdata[hsc_pkg::HSC_INSERT_BIT];
    assign ext_clr    = csr_wr && CFG_REQ.wdata[hsc_pkg::HSC_EXT_BIT];

    // ****************************************
    // Sticky flags
    // ****************************************
    hsc_flag u_flag_insert (
        .MCLK   (MCLK),
        .RESET  (RESET),
        .set_evt(insert_set),
        .clr_req(insert_clr),
        .flag   (board_inserted_flag)
    );

    hsc_flag u_flag_ext (
        .MCLK   (MCLK),
        .RESET  (RESET),
        .set_evt(ext_set),
        .clr_req(ext_clr),
        .flag   (extraction_flag)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d               = st_q;
        st_d.handle_was_q  = handle_sync;
        st_d.removal_was_q = removal_sync;
        if (csr_wr) begin
            st_d.indicator_led_control = CFG_REQ.wdata[hsc_pkg::HSC_LED_BIT];
            st_d.enumeration_mask      = CFG_REQ.wdata[hsc_pkg::HSC_MASK_BIT];
        end
        st_d.enum_n = !((board_inserted_flag || extraction_flag) && !st_q.enumeration_mask);
        st_d.rsp_valid = hit && !CFG_REQ.write;
        st_d.rsp_data  = 32'h0000_0000;
        if (hit && !CFG_REQ.write) begin
            st_d.rsp_data[hsc_pkg::HSC_CAP_ID_LSB +: 8]   = hsc_pkg::HSC_CAP_ID_VALUE;
            st_d.rsp_data[hsc_pkg::HSC_NEXT_PTR_LSB +: 8] = hsc_pkg::HSC_NEXT_PTR_VALUE;
            st_d.rsp_data[hsc_pkg::HSC_INSERT_BIT] = board_inserted_flag;
            st_d.rsp_data[hsc_pkg::HSC_EXT_BIT]  = extraction_flag;
            st_d.rsp_data[hsc_pkg::HSC_LED_BIT]  = st_q.indicator_led_control;
            st_d.rsp_data[hsc_pkg::HSC_MASK_BIT] = st_q.enumeration_mask;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_q        <= '0;
            st_q.enum_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign ENUM_N        = st_q.enum_n;
    assign LED_ON        = st_q.indicator_led_control;
    assign CFG_RSP.valid = st_q.rsp_valid;
    assign CFG_RSP.rdata = st_q.rsp_data;
endmodule
`default_nettype wire

/* File: hsc_checker.sv */
// Assertions on the hot swap capability register set
`timescale 1ns/1ps
`default_nettype none
module hsc_checker (
    // Clock and reset
    input wire logic                  MCLK,
    input wire logic                  RESET,
    // Watched ports
    input wire hsc_pkg::hsc_cfg_req_s CFG_REQ,
    input wire hsc_pkg::hsc_cfg_rsp_s CFG_RSP,
    input wire logic                  EJECTOR_CLOSED,
    input wire logic                  REMOVAL_REQUEST,
    input wire logic                  ENUM_N,
    input wire logic                  LED_ON
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    wire logic        hit = CFG_REQ.valid && CFG_REQ.addr == 8'hE4;
    wire logic        wr  = hit && CFG_REQ.write && !CFG_REQ.primary_byte_enables_n[2];
    wire logic        rv  = CFG_RSP.valid;
    wire logic [31:0] d   = CFG_RSP.rdata;
    a_read_answer: assert property (hit && !CFG_REQ.write |=> rv)
        else $error("read not answered");
    a_ident_byte: assert property (rv |-> d[7:0] == 8'h06)
        else $error("bad identifier");
    a_next_zero: assert property (rv |-> d[15:8] == 8'h00)
        else $error("bad next pointer");
    a_reserved_zero: assert property (rv |-> (d & 32'hFF35_0000) == 32'h0000_0000)
        else $error("reserved bit set");
    a_led_write: assert property (wr |=> LED_ON == $past(CFG_REQ.wdata[19]))
        else $error("led not written");
    a_led_readback: assert property (rv |-> d[19] == LED_ON)
        else $error("led differs from bit");
    a_enum_relation: assert property (rv |-> ENUM_N == !((d[23] || d[22]) && !d[17]))
        else $error("enumeration level wrong");
    a_reset_quiet: assert property ($fell(RESET) |-> ENUM_N [*2])
        else $error("enumeration right after reset");
endmodule
bind hsc_regs hsc_checker u_chk (.MCLK(MCLK), .RESET(RESET), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
    .EJECTOR_CLOSED(EJECTOR_CLOSED), .REMOVAL_REQUEST(REMOVAL_REQUEST), .ENUM_N(ENUM_N),
    .LED_ON(LED_ON));
`default_nettype wire

/* File: hsc_host.sv */
// Host model counting enumeration requests
`timescale 1ns/1ps
`default_nettype none
module hsc_host (
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RESET,
    // Enumeration line and count
    input  wire logic ENUM_N,
    output var int    events
);
    logic last_q = 1'b1;
    always @(posedge MCLK) begin
        events <= RESET ? 0 : events + int'(last_q && !ENUM_N);
        last_q <= RESET | ENUM_N;
    end
endmodule
`default_nettype wire

/* File: tb_hot_swap_capability_regs.sv */
// Self-checking bench for the hot swap capability register set
`timescale 1ns/1ps
`default_nettype none
module tb_hot_swap_capability_regs;
    logic                  MCLK = 1'b0;
    logic                  RESET = 1'b1;
    hsc_pkg::hsc_cfg_req_s CFG_REQ = '0;
    hsc_pkg::hsc_cfg_rsp_s CFG_RSP;
    logic                  EJECTOR_CLOSED = 1'b0;
    logic                  REMOVAL_REQUEST = 1'b0;
    logic                  ENUM_N, LED_ON, inserted, ext, led, mask;
    int                    events, bad_count = 0, cmp_count = 0;
    logic [31:0]           lfsr = 32'h0001_2BF7, exp_q[$];
    hsc_regs DUT (.MCLK(MCLK), .RESET(RESET), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
        .EJECTOR_CLOSED(EJECTOR_CLOSED), .REMOVAL_REQUEST(REMOVAL_REQUEST), .ENUM_N(ENUM_N),
        .LED_ON(LED_ON));
    hsc_host u_host (.MCLK(MCLK), .RESET(RESET), .ENUM_N(ENUM_N), .events(events));
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        chk("pending answers", 32'd0, exp_q.size());
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cfg(logic w, logic [7:0] a, logic [3:0] be_n, logic [31:0] wd);
        @(posedge MCLK);
        #1 CFG_REQ = {1'b1, w, a, be_n, wd};
        @(posedge MCLK);
        #1 CFG_REQ.valid = 1'b0;
    endtask
    task automatic rd();
        exp_q.push_back({8'h00, inserted, ext, 2'b00, led, 1'b0, mask, 1'b0, 16'h0006});
        cfg(1'b0, 8'hE4, 4'b0000, rnd());
    endtask
    task automatic wr(logic w_ins, logic w_ext, logic w_led, logic w_mask, logic [3:0] be_n);
        logic [31:0] wd;
        wd = (rnd() & 32'hFF35_FFFF) | {8'h00, w_ins, w_ext, 2'b00, w_led, 1'b0, w_mask, 17'h0};
        cfg(1'b1, 8'hE4, be_n, wd);
        if (!be_n[2]) begin
            {inserted, ext, led, mask} = {inserted & ~w_ins, ext & ~w_ext, w_led, w_mask};
        end
        repeat (2) @(posedge MCLK);
        #1;
        chk("enum pin", {31'h0, ~((inserted | ext) & ~mask)}, {31'h0, ENUM_N});
        chk("led pin", {31'h0, led}, {31'h0, LED_ON});
        rd();
    endtask
    // Answers are matched against the oldest noted read
    always @(negedge MCLK) begin
        if (CFG_RSP.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected answer", 32'h0000_0000, 32'hFFFF_FFFF);
            end else begin
                chk("read data", exp_q.pop_front(), CFG_RSP.rdata);
            end
        end
    end
    initial begin
        {inserted, ext, led, mask} = 4'h0;
        repeat (4) @(posedge MCLK);
        #1 RESET = 1'b0;
        wr(1'b0, 1'b0, 1'b0, 1'b0, 4'b1111);
        wr(1'b1, 1'b1, 1'b1, 1'b1, 4'b1011);
        wr(1'b0, 1'b0, 1'b0, 1'b0, 4'b1111);
        cfg(1'b0, 8'hE0, 4'b0000, 32'h0000_0000);
        $display("register test done");
        EJECTOR_CLOSED = 1'b1;
        repeat (6) @(posedge MCLK);
        inserted = 1'b1;
        wr(1'b0, 1'b0, 1'b1, 1'b1, 4'b1011);
        wr(1'b0, 1'b0, 1'b1, 1'b0, 4'b1011);
        chk("host events", 32'd1, events);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 4'b1011);
        $display("insertion test done");
        REMOVAL_REQUEST = 1'b1;
        repeat (6) @(posedge MCLK);
        ext = 1'b1;
        wr(1'b0, 1'b0, 1'b0, 1'b0, 4'b1011);
        chk("host events", 32'd2, events);
        wr(1'b0, 1'b1, 1'b0, 1'b0, 4'b1011);
        $display("removal test done");
        wr(1'b0, 1'b0, 1'b1, 1'b1, 4'b1011);
        @(posedge MCLK);
        #1 RESET = 1'b1;
        repeat (2) @(posedge MCLK);
        #1 RESET = 1'b0;
        {inserted, ext, led, mask} = 4'h0;
        repeat (6) @(posedge MCLK);
        {inserted, ext} = 2'b11;
        wr(1'b0, 1'b0, 1'b0, 1'b0, 4'b1111);
        chk("host events", 32'd1, events);
        wr(1'b1, 1'b1, 1'b0, 1'b0, 4'b1011);
        $display("reset test done");
        repeat (2) @(posedge MCLK);
        stop_test();
    end
    initial begin
        #5000;
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
